// file: verilog/pdcr_map.svh
// register offsets, field positions, defaults and decode constants for the panel drive configuration bank
`ifndef PDCR_MAP_SVH
`define PDCR_MAP_SVH
`define PDCR_ADDR_PSTART_LOW 16'hc500
`define PDCR_ADDR_PSTART_HIGH 16'hc501
`define PDCR_ADDR_PEND_LOW 16'hc502
`define PDCR_ADDR_PEND_HIGH 16'hc503
`define PDCR_ADDR_SRC_DIR 16'hc700
`define PDCR_ADDR_PDOT 16'hc800
`define PDCR_ADDR_COLOUR 16'hcd00
`define PDCR_ADDR_SPREAD 16'hce00
`define PDCR_RST_PSTART_LOW 8'h00
`define PDCR_RST_PSTART_HIGH 8'h00
`define PDCR_RST_PEND_LOW 8'h5f
`define PDCR_RST_PEND_HIGH 8'h03
`define PDCR_RST_SRC_DIR 8'h00
`define PDCR_RST_PDOT 8'h00
`define PDCR_RST_COLOUR 8'h00
`define PDCR_RST_SPREAD 8'h00
`define PDCR_BIT_SRC_DIR 2
`define PDCR_BIT_PDOT_DISABLE 7
`define PDCR_BIT_DUMMY_SEL 6
`define PDCR_BIT_SIDE_SEL 5
`define PDCR_BIT_PWM_INV 5
`define PDCR_BIT_ON_INV 4
`define PDCR_BIT_ARRANGE 3
`define PDCR_BIT_SS_EN 7
`define PDCR_SOURCE_LAST 9'h1df
`endif

// file: verilog/pdcr_pkg.sv
// types for the panel drive configuration bank
package pdcr_pkg;
  // host write on the command link
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } pdcr_write_type;
  // decoded low-bit fill schemes
  typedef enum logic [2:0] {
    PDCR_FILL_OWN_MSB = 3'h0,
    PDCR_FILL_GREEN_MSB = 3'h1,
    PDCR_FILL_OWN_LSB = 3'h2,
    PDCR_FILL_ZERO = 3'h4,
    PDCR_FILL_ONE = 3'h5
  } pdcr_fill_type;
  // settings handed to the panel datapath
  typedef struct packed {
    logic [9:0] partial_start_line;
    logic [9:0] partial_end_line;
    logic source_reverse;
    logic [8:0] source_first_index;
    logic pseudo_dot_active;
    logic first_dummy_scheme;
    logic second_dummy_scheme;
    logic right_side_first;
    logic pixel_arrangement_bit;
    logic [2:0] low_bit_fill_code;
    logic fill_code_valid;
    logic spread_spectrum_enable;
    logic [1:0] spread_range_field;
    logic [6:0] spread_deviation_permille;
  } pdcr_config_type;
endpackage

// file: verilog/pdcr_regs.sv
// panel drive configuration register bank and backlight polarity outputs
`timescale 1ns/10ps
`include "pdcr_map.svh"
module pdcr_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic soft_reset,
  input wire pdcr_pkg::pdcr_write_type host_write,
  input wire logic backlight_pwm_raw,
  input wire logic backlight_on_raw,
  output pdcr_pkg::pdcr_config_type config_out,
  output logic backlight_pwm_out,
  output logic backlight_on_out
);
  import pdcr_pkg::*;

  // ********************************************************
  // register storage
  // ********************************************************
  logic [7:0] pstart_low_reg;
  logic [7:0] pstart_high_reg;
  logic [7:0] pend_low_reg;
  logic [7:0] pend_high_reg;
  logic [7:0] src_dir_reg;
  logic [7:0] pdot_reg;
  logic [7:0] colour_reg;
  logic [7:0] spread_reg;
  pdcr_config_type config_next;

  // true when the fill code names one of the defined schemes
  function automatic logic fill_known(input logic [2:0] code);
    case (code)
      PDCR_FILL_OWN_MSB, PDCR_FILL_GREEN_MSB, PDCR_FILL_OWN_LSB, PDCR_FILL_ZERO, PDCR_FILL_ONE: fill_known = 1'b1;
      default: fill_known = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input pdcr_write_type w, input logic [15:0] a);
    hit = w.valid && (w.addr == a);
  endfunction

  // writes are taken in any power state; no sleep gating here on purpose
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pstart_low_reg <= `PDCR_RST_PSTART_LOW;
      pstart_high_reg <= `PDCR_RST_PSTART_HIGH;
      pend_low_reg <= `PDCR_RST_PEND_LOW;
      pend_high_reg <= `PDCR_RST_PEND_HIGH;
      src_dir_reg <= `PDCR_RST_SRC_DIR;
      pdot_reg <= `PDCR_RST_PDOT;
      colour_reg <= `PDCR_RST_COLOUR;
      spread_reg <= `PDCR_RST_SPREAD;
    end else if (soft_reset) begin
      pstart_low_reg <= `PDCR_RST_PSTART_LOW;
      pstart_high_reg <= `PDCR_RST_PSTART_HIGH;
      pend_low_reg <= `PDCR_RST_PEND_LOW;
      pend_high_reg <= `PDCR_RST_PEND_HIGH;
      src_dir_reg <= `PDCR_RST_SRC_DIR;
      pdot_reg <= `PDCR_RST_PDOT;
      colour_reg <= `PDCR_RST_COLOUR;
      spread_reg <= `PDCR_RST_SPREAD;
    end else begin
      if (hit(host_write, `PDCR_ADDR_PSTART_LOW)) pstart_low_reg <= host_write.data;
      if (hit(host_write, `PDCR_ADDR_PSTART_HIGH)) pstart_high_reg <= host_write.data;
      if (hit(host_write, `PDCR_ADDR_PEND_LOW)) pend_low_reg <= host_write.data;
      if (hit(host_write, `PDCR_ADDR_PEND_HIGH)) pend_high_reg <= host_write.data;
      if (hit(host_write, `PDCR_ADDR_SRC_DIR)) src_dir_reg <= host_write.data;
      if (hit(host_write, `PDCR_ADDR_PDOT)) pdot_reg <= host_write.data;
      if (hit(host_write, `PDCR_ADDR_COLOUR)) colour_reg <= host_write.data;
      // fixed pattern bits are stored as written; the host owns them
      if (hit(host_write, `PDCR_ADDR_SPREAD)) spread_reg <= host_write.data;
    end
  end

  // ********************************************************
  // decode of stored fields
  // ********************************************************
  always_comb begin
    config_next = '0;
    config_next.partial_start_line = {pstart_high_reg[1:0], pstart_low_reg};
    config_next.partial_end_line = {pend_high_reg[1:0], pend_low_reg};
    config_next.source_reverse = src_dir_reg[`PDCR_BIT_SRC_DIR];
    config_next.source_first_index = src_dir_reg[`PDCR_BIT_SRC_DIR] ? `PDCR_SOURCE_LAST : 9'h000;
    config_next.pseudo_dot_active = ~pdot_reg[`PDCR_BIT_PDOT_DISABLE];
    // dummy schemes only matter while pseudo-dot drive is active
    config_next.first_dummy_scheme = config_next.pseudo_dot_active & pdot_reg[`PDCR_BIT_DUMMY_SEL];
    config_next.second_dummy_scheme = config_next.pseudo_dot_active & ~pdot_reg[`PDCR_BIT_DUMMY_SEL];
    config_next.right_side_first = pdot_reg[`PDCR_BIT_SIDE_SEL];
    config_next.pixel_arrangement_bit = colour_reg[`PDCR_BIT_ARRANGE];
    config_next.low_bit_fill_code = colour_reg[2:0];
    // codes 3, 6 and 7 have no scheme; flagged so the datapath can hold its default
    config_next.fill_code_valid = fill_known(colour_reg[2:0]);
    config_next.spread_spectrum_enable = spread_reg[`PDCR_BIT_SS_EN];
    config_next.spread_range_field = spread_reg[5:4];
    case (spread_reg[5:4])
      2'h0: config_next.spread_deviation_permille = 7'h00;
      2'h1: config_next.spread_deviation_permille = 7'h19;
      2'h2: config_next.spread_deviation_permille = 7'h32;
      default: config_next.spread_deviation_permille = 7'h4b;
    endcase
  end

  // registered outputs; one cycle after the write lands
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_out <= '0;
      backlight_pwm_out <= 1'b0;
      backlight_on_out <= 1'b0;
    end else begin
      config_out <= config_next;
      backlight_pwm_out <= backlight_pwm_raw ^ colour_reg[`PDCR_BIT_PWM_INV];
      backlight_on_out <= backlight_on_raw ^ colour_reg[`PDCR_BIT_ON_INV];
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  property p_start_line;
    @(posedge core_clk) disable iff (sys_rst)
    hit(host_write, `PDCR_ADDR_PSTART_HIGH) && !soft_reset |=> ##1 config_out.partial_start_line[9:8] == $past(host_write.data[1:0], 2);
  endproperty
  a_start_line: assert property (p_start_line) else $error("start line high bits wrong");

  property p_end_line;
    @(posedge core_clk) disable iff (sys_rst)
    hit(host_write, `PDCR_ADDR_PEND_LOW) && !soft_reset |=> ##1 config_out.partial_end_line[7:0] == $past(host_write.data, 2);
  endproperty
  a_end_line: assert property (p_end_line) else $error("end line low byte wrong");

  property p_source_dir;
    @(posedge core_clk) disable iff (sys_rst)
    config_out.source_reverse |-> config_out.source_first_index == 9'h1df;
  endproperty
  a_source_dir: assert property (p_source_dir) else $error("reverse scan must start at 479");

  property p_pdot;
    @(posedge core_clk) disable iff (sys_rst)
    !config_out.pseudo_dot_active |-> !config_out.first_dummy_scheme && !config_out.second_dummy_scheme;
  endproperty
  a_pdot: assert property (p_pdot) else $error("dummy scheme active with pseudo-dot off");

  property p_dummy;
    @(posedge core_clk) disable iff (sys_rst)
    config_out.pseudo_dot_active |-> config_out.first_dummy_scheme != config_out.second_dummy_scheme;
  endproperty
  a_dummy: assert property (p_dummy) else $error("exactly one dummy scheme expected");

  property p_pwm_pol;
    @(posedge core_clk) disable iff (sys_rst)
    $stable(colour_reg) |=> backlight_pwm_out == ($past(backlight_pwm_raw) ^ $past(colour_reg[5]));
  endproperty
  a_pwm_pol: assert property (p_pwm_pol) else $error("backlight pwm polarity wrong");

  sequence s_soft_reset;
    soft_reset ##1 !soft_reset;
  endsequence
  property p_defaults;
    @(posedge core_clk) disable iff (sys_rst)
    s_soft_reset |=> config_out.partial_end_line == 10'h35f && !config_out.spread_spectrum_enable;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not reloaded");

  property p_range;
    @(posedge core_clk) disable iff (sys_rst)
    config_out.spread_range_field == 2'h2 |-> config_out.spread_deviation_permille == 7'h32;
  endproperty
  a_range: assert property (p_range) else $error("spread range decode wrong");

  // zero range means no spread at all, whatever the enable bit says
  property p_range_off;
    @(posedge core_clk) disable iff (sys_rst)
    config_out.spread_range_field == 2'h0 |-> config_out.spread_deviation_permille == 7'h00;
  endproperty
  a_range_off: assert property (p_range_off) else $error("range zero must give no spread");

  property p_range_top;
    @(posedge core_clk) disable iff (sys_rst)
    config_out.spread_range_field == 2'h3 |-> config_out.spread_deviation_permille == 7'h4b;
  endproperty
  a_range_top: assert property (p_range_top) else $error("widest range decode wrong");

  // pseudo-dot, dummy scheme, start line and direction defaults, one edge behind the stored bytes
  property p_defaults_pdot;
    @(posedge core_clk) disable iff (sys_rst)
    s_soft_reset |=> config_out.pseudo_dot_active && config_out.second_dummy_scheme &&
      config_out.partial_start_line == 10'h000 && !config_out.source_reverse;
  endproperty
  a_defaults_pdot: assert property (p_defaults_pdot) else $error("pseudo-dot defaults not reloaded");

  // no polarity gate on the enable path, unlike the $stable(colour_reg) gate of the pwm check; raw level seen one edge late
  property p_on_pol;
    @(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> backlight_on_out == ($past(backlight_on_raw) ^ $past(colour_reg[`PDCR_BIT_ON_INV]));
  endproperty
  a_on_pol: assert property (p_on_pol) else $error("backlight on polarity wrong");

  // a write that a software reset in the same cycle does not override
  sequence s_pdot_write;
    hit(host_write, `PDCR_ADDR_PDOT) && !soft_reset;
  endsequence
  sequence s_colour_write;
    hit(host_write, `PDCR_ADDR_COLOUR) && !soft_reset;
  endsequence
  sequence s_spread_write;
    hit(host_write, `PDCR_ADDR_SPREAD) && !soft_reset;
  endsequence

  property p_side;
    @(posedge core_clk) disable iff (sys_rst)
    s_pdot_write |=> ##1 config_out.right_side_first == $past(host_write.data[`PDCR_BIT_SIDE_SEL], 2);
  endproperty
  a_side: assert property (p_side) else $error("side select not applied");

  property p_arrange;
    @(posedge core_clk) disable iff (sys_rst)
    s_colour_write |=> ##1 config_out.pixel_arrangement_bit == $past(host_write.data[`PDCR_BIT_ARRANGE], 2);
  endproperty
  a_arrange: assert property (p_arrange) else $error("arrangement bit not applied");

  // codes without a scheme must never be flagged usable
  property p_fill_valid;
    @(posedge core_clk) disable iff (sys_rst)
    config_out.fill_code_valid |-> !(config_out.low_bit_fill_code inside {3'h3, 3'h6, 3'h7});
  endproperty
  a_fill_valid: assert property (p_fill_valid) else $error("undefined fill code flagged valid");

  property p_ss_en;
    @(posedge core_clk) disable iff (sys_rst)
    s_spread_write |=> ##1 config_out.spread_spectrum_enable == $past(host_write.data[`PDCR_BIT_SS_EN], 2) &&
      config_out.spread_range_field == $past(host_write.data[5:4], 2);
  endproperty
  a_ss_en: assert property (p_ss_en) else $error("spread control not applied");

  // no power-state input exists, so a direction write must land unless a software reset comes in the same cycle
  property p_src_write;
    @(posedge core_clk) disable iff (sys_rst)
    hit(host_write, `PDCR_ADDR_SRC_DIR) && !soft_reset |=> ##1
      config_out.source_reverse == $past(host_write.data[`PDCR_BIT_SRC_DIR], 2);
  endproperty
  a_src_write: assert property (p_src_write) else $error("direction write lost");

  property p_start_low;
    @(posedge core_clk) disable iff (sys_rst)
    hit(host_write, `PDCR_ADDR_PSTART_LOW) && !soft_reset |=> ##1
      config_out.partial_start_line[7:0] == $past(host_write.data, 2);
  endproperty
  a_start_low: assert property (p_start_low) else $error("start line low byte wrong");

  property p_end_high;
    @(posedge core_clk) disable iff (sys_rst)
    hit(host_write, `PDCR_ADDR_PEND_HIGH) && !soft_reset |=> ##1
      config_out.partial_end_line[9:8] == $past(host_write.data[1:0], 2);
  endproperty
  a_end_high: assert property (p_end_high) else $error("end line high bits wrong");
endmodule

// file: tb/pdcr_host_model.sv
// host processor model issuing parameter writes to the configuration bank
`timescale 1ns/10ps
`include "pdcr_map.svh"
module pdcr_host_model (
  input wire logic core_clk,
  output pdcr_pkg::pdcr_write_type host_write
);
  import pdcr_pkg::*;
  // ****************
  // parameter writes
  // ****************
  // valid stays high so calls may run back to back
  task automatic send(input logic [15:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    // spread byte keeps its fixed bits: bit 6 low, 0100 below
    if (addr == `PDCR_ADDR_SPREAD) d = {d[7], 1'b0, d[5:4], 4'h4};
    @(posedge core_clk);
    host_write <= '{valid: 1'b1, addr: addr, data: d};
  endtask
  // released lines do not keep the last value
  task automatic idle();
    @(posedge core_clk);
    host_write <= '{valid: 1'b0, addr: ~host_write.addr, data: ~host_write.data};
  endtask
  initial host_write = '0;
endmodule

// file: tb/pdcr_regs_tb.sv
// self-checking bench for the panel drive configuration bank
`timescale 1ns/10ps
`include "pdcr_map.svh"
module pdcr_regs_tb;
  import pdcr_pkg::*;
  localparam logic [15:0] addr_tab [8] = '{`PDCR_ADDR_PSTART_LOW, `PDCR_ADDR_PSTART_HIGH, `PDCR_ADDR_PEND_LOW,
    `PDCR_ADDR_PEND_HIGH, `PDCR_ADDR_SRC_DIR, `PDCR_ADDR_PDOT, `PDCR_ADDR_COLOUR, `PDCR_ADDR_SPREAD};
  localparam logic [7:0] dflt_tab [8] = '{8'h00, 8'h00, 8'h5f, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  logic core_clk, sys_rst, soft_reset, pwm_raw, on_raw, pwm_out, on_out;
  pdcr_write_type host_write;
  pdcr_config_type config_out;
  logic [7:0] shadow [8];
  int bad_count, n_tests, cycles;
  pdcr_host_model host_i (.core_clk(core_clk), .host_write(host_write));
  pdcr_regs pdcr_regs_i (.core_clk(core_clk), .sys_rst(sys_rst), .soft_reset(soft_reset),
    .host_write(host_write), .backlight_pwm_raw(pwm_raw), .backlight_on_raw(on_raw),
    .config_out(config_out), .backlight_pwm_out(pwm_out), .backlight_on_out(on_out));
  // ****************
  // expectations
  // ****************
  // decoded settings worked out from the shadow bytes
  function automatic pdcr_config_type expect_cfg();
    pdcr_config_type c;
    c.partial_start_line = {shadow[1][1:0], shadow[0]};
    c.partial_end_line = {shadow[3][1:0], shadow[2]};
    c.source_reverse = shadow[4][2];
    c.source_first_index = shadow[4][2] ? 9'h1df : 9'h000;
    c.pseudo_dot_active = ~shadow[5][7];
    c.first_dummy_scheme = ~shadow[5][7] & shadow[5][6];
    c.second_dummy_scheme = ~shadow[5][7] & ~shadow[5][6];
    c.right_side_first = shadow[5][5];
    c.pixel_arrangement_bit = shadow[6][3];
    c.low_bit_fill_code = shadow[6][2:0];
    c.fill_code_valid = shadow[6][2:0] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    c.spread_spectrum_enable = shadow[7][7];
    c.spread_range_field = shadow[7][5:4];
    c.spread_deviation_permille = 7'(shadow[7][5:4] * 25);
    return c;
  endfunction
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_all();
    compare(64'({config_out, pwm_out, on_out}),
      64'({expect_cfg(), pwm_raw ^ shadow[6][5], on_raw ^ shadow[6][4]}));
  endtask
  task automatic put(input int i, input logic [7:0] d);
    host_i.send(addr_tab[i], d);
    shadow[i] = (i == 7) ? {d[7], 1'b0, d[5:4], 4'h4} : d;
  endtask
  // lets the last write land, with fresh backlight levels
  task automatic settle();
    host_i.idle();
    pwm_raw <= 1'($urandom_range(1));
    on_raw <= 1'($urandom_range(1));
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************
  // clock, watchdog and tests
  // ****************
  always #12.5 core_clk = ~core_clk;
  // a hang ends the run as a mismatch
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    core_clk = 0; sys_rst = 1; soft_reset = 0; pwm_raw = 0; on_raw = 0; cycles = 0;
    shadow = dflt_tab;
    void'($urandom(32'ha5f2));
    repeat (5) @(posedge core_clk);
    #1 compare(64'({config_out, pwm_out, on_out}), 64'h0);
    @(posedge core_clk) sys_rst <= 1'b0;
    settle();
    check_all();
    $display("test reset defaults done");
    // every code of each direction, pseudo-dot, colour and spread field, four writes back to back
    for (int k = 0; k < 8; k++) begin
      put(4, 8'(k << 2));
      put(5, 8'(k << 5));
      put(6, 8'(k * 9));
      put(7, {k[2], 1'b0, k[1:0], 4'h0});
      settle();
      check_all();
    end
    $display("test field codes done");
    repeat (40) begin
      put($urandom_range(7), 8'($urandom));
      put($urandom_range(7), 8'($urandom));
      settle();
      check_all();
    end
    $display("test random writes done");
    // unmapped places leave every register alone
    host_i.send(16'hc504, 8'($urandom));
    host_i.send(16'hc600, 8'($urandom));
    settle();
    check_all();
    $display("test unmapped done");
    // software reset wins over a write in the same cycle
    put(2, 8'h11);
    soft_reset <= 1'b1;
    host_i.idle();
    soft_reset <= 1'b0;
    shadow = dflt_tab;
    settle();
    check_all();
    $display("test soft reset done");
    // a write landing just before the hard reset must not survive it
    put(3, 8'h01);
    host_i.idle();
    sys_rst <= 1'b1;
    #1 compare(64'({config_out, pwm_out, on_out}), 64'h0);
    @(posedge core_clk) sys_rst <= 1'b0;
    shadow = dflt_tab;
    settle();
    check_all();
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
